/* File: wdh_map.svh */
`ifndef WDH_MAP_SVH
`define WDH_MAP_SVH
// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define WDH_IDX_STATUS 10'h00a
`define WDH_IDX_IRQ_CTRL 10'h00b
`define WDH_IDX_WD_PRESCALE 10'h00c
// ----------------------------------------------------------------------
// Field positions and masks.
// ----------------------------------------------------------------------
`define WDH_IRQ_GLOBAL_EN 0
`define WDH_IRQ_T0_EN 2
`define WDH_IRQ_T1_EN 3
`define WDH_IRQ_T0_PEND 5
`define WDH_IRQ_T1_PEND 6
`define WDH_IRQ_RW_MASK 8'h6d
`define WDH_STAT_PDF 4
`define WDH_STAT_TO 5
`define WDH_PS_SEL_HI 2
`define WDH_PS_SEL_LO 0
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define WDH_IRQ_RESET 8'h00
`define WDH_PS_RESET 8'h07
`define WDH_SYNC_RESET 10'h3ff
// ----------------------------------------------------------------------
// Timing, in nanoseconds, clock periods or stage counts.
// ----------------------------------------------------------------------
`define WDH_REF_PERIOD_NS 100
`define WDH_SYS_DIV 2
`define WDH_INSTR_DIV 4
`define WDH_BASE_STAGES 8
`define WDH_PS_STAGES 7
`define WDH_SST_CYCLES 1024
`define WDH_IRQ_EXTRA_CYCLES 1
`endif

/* File: wdh_pkg.sv */
package wdh_pkg;
  typedef enum {S_RUN, S_HALT, S_WAIT, S_EXTRA} wdh_state_type;
  typedef enum {W_PORT, W_IRQ_NEXT, W_IRQ_SERVE, W_WARM} wdh_wake_type;
endpackage : wdh_pkg

/* File: wdh_watchdog_halt.sv */
// Function
// - System clock enable is the oscillator divided by two in either oscillator type.
// - In RC mode the clock output pin carries system clock divided by four.
// - Watchdog ticks from its own oscillator or the instruction clock, by option.
// - With the watchdog disabled, clears and prescaler writes do nothing.
// - Watchdog ticks pass an eight-stage divide-by-256 stage first.
// - Prescale select bits 2..0 add division 1:1 up to 1:128.
// - Bit 3 and the high nibble of the prescale register are plain storage.
// - Overflow while running gives a full chip reset and sets the expired flag.
// - Overflow while halted gives a warm reset of program counter and stack pointer.
// - External reset low, clear instructions or halt clear counter and prescaler.
// - Single option clears on one instruction; double option needs both instructions.
// - With the instruction clock source the watchdog stops during halt.
// - Halt stops the system oscillator, keeps state, restarts the cleared watchdog.
// - Halt sets the sleep flag and clears the expired flag.
// - Power-up or a watchdog clear instruction clears the sleep flag.
// - The halt output pin is high during halt.
// - Halt ends on external reset, interrupt, enabled port falling edge or overflow.
// - Port A wake-up bits are enabled by option and resume at next instruction.
// - Interrupt wake resumes next unless enabled with stack free, then service.
// - Wake waits 1024 system clocks; interrupt service one instruction cycle more.
// - An interrupt pending at halt entry cannot wake the device.
// - Interrupt control bits 0,2,3 enable, 5,6 pending; bits 1,4,7 read zero.
`include "wdh_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdh_watchdog_halt #(
  parameter bit RC_MODE = 1'b1,
  parameter bit WD_ENABLE = 1'b1,
  parameter bit WD_USE_OSC = 1'b1,
  parameter bit WD_DOUBLE_CLEAR = 1'b0,
  parameter logic [7:0] PA_WAKE_MASK = 8'hff
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_external_rst_n,
  input wire logic i_wd_osc,
  input wire logic [7:0] i_port_a,
  input wire logic i_halt_exec,
  input wire logic i_wd_clear_single,
  input wire logic i_wd_clear_first,
  input wire logic i_wd_clear_second,
  input wire logic i_stack_full,
  input wire logic i_timer0_irq_set,
  input wire logic i_timer1_irq_set,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_sys_clk_en,
  output logic o_clock_pin_out,
  output logic o_halt,
  output logic o_chip_rst,
  output logic o_warm_rst,
  output logic o_resume_next,
  output logic o_irq_service
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int SYW = $clog2(`WDH_SYS_DIV);
  localparam int IW = $clog2(`WDH_INSTR_DIV);
  localparam int SW = $clog2(`WDH_SST_CYCLES);
  localparam int CW = `WDH_BASE_STAGES + `WDH_PS_STAGES;
  localparam int EXTRA = `WDH_INSTR_DIV * `WDH_IRQ_EXTRA_CYCLES;
  generate
    if (SYW < 1 || IW < 1 || EXTRA > `WDH_SST_CYCLES)
    begin : g_bad
      $error("Clock divider settings cannot be served.");
    end
  endgenerate
  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_s1_q, rst_n;
  logic [9:0] sync1_q, sync2_q;
  logic osc_prev_q;
  logic [7:0] pa_prev_q;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= `WDH_SYNC_RESET;
      sync2_q <= `WDH_SYNC_RESET;
      osc_prev_q <= 1'b1;
      pa_prev_q <= 8'hff;
    end
    else
    begin
      sync1_q <= {i_wd_osc, i_external_rst_n, i_port_a};
      sync2_q <= sync1_q;
      osc_prev_q <= sync2_q[9];
      pa_prev_q <= sync2_q[7:0];
    end
  end
  logic ext_rst_low, osc_tick, port_wake;
  assign ext_rst_low = !sync2_q[8];
  assign osc_tick = sync2_q[9] && !osc_prev_q;
  assign port_wake = |(pa_prev_q & ~sync2_q[7:0] & PA_WAKE_MASK);
  // ----------------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------------
  wdh_pkg::wdh_state_type state_q;
  logic osc_run, sys_en, instr_en;
  logic [SYW-1:0] sys_cnt_q;
  logic [IW-1:0] instr_cnt_q;
  // The system oscillator is off only while halted; the wake wait runs it.
  assign osc_run = (state_q != wdh_pkg::S_HALT);
  assign sys_en = osc_run && (sys_cnt_q == SYW'(`WDH_SYS_DIV - 1));
  assign instr_en = sys_en && (instr_cnt_q == IW'(`WDH_INSTR_DIV - 1));
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_cnt_q <= '0;
      instr_cnt_q <= '0;
      o_sys_clk_en <= 1'b0;
      o_clock_pin_out <= 1'b0;
    end
    else
    begin
      if (osc_run)
        sys_cnt_q <= sys_en ? '0 : sys_cnt_q + SYW'(1);
      if (sys_en)
        instr_cnt_q <= instr_cnt_q + IW'(1);
      o_sys_clk_en <= sys_en;
      if (RC_MODE && sys_en && instr_cnt_q[0])
        o_clock_pin_out <= !o_clock_pin_out;
    end
  end
  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  logic [7:0] ps_q, irq_q;
  logic [CW-1:0] wd_cnt_q, wd_mask;
  logic clr_first_q, clr_second_q;
  logic halt_go, wd_sw_clear, wd_tick, wd_full, wd_ovf, wd_clear;
  assign halt_go = i_halt_exec && (state_q == wdh_pkg::S_RUN);
  // The double option only clears once both halves have been seen, in any order.
  assign wd_sw_clear = WD_ENABLE && (WD_DOUBLE_CLEAR ?
    ((clr_first_q || i_wd_clear_first) && (clr_second_q || i_wd_clear_second)) :
    i_wd_clear_single);
  // The instruction clock dies in halt, so that source cannot catch a hang there.
  assign wd_tick = WD_USE_OSC ? osc_tick : instr_en;
  assign wd_mask = ~({CW{1'b1}} << (`WDH_BASE_STAGES + ps_q[`WDH_PS_SEL_HI:`WDH_PS_SEL_LO]));
  assign wd_full = ((wd_cnt_q & wd_mask) == wd_mask);
  assign wd_clear = ext_rst_low || wd_sw_clear || halt_go;
  assign wd_ovf = WD_ENABLE && wd_tick && wd_full && !wd_clear;
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_cnt_q <= '0;
      clr_first_q <= 1'b0;
      clr_second_q <= 1'b0;
    end
    else
    begin
      if (!WD_ENABLE || wd_clear || wd_ovf)
        wd_cnt_q <= '0;
      else if (wd_tick)
        wd_cnt_q <= wd_cnt_q + CW'(1);
      if (wd_clear || wd_ovf)
      begin
        clr_first_q <= 1'b0;
        clr_second_q <= 1'b0;
      end
      else
      begin
        clr_first_q <= clr_first_q || i_wd_clear_first;
        clr_second_q <= clr_second_q || i_wd_clear_second;
      end
    end
  end
  // ----------------------------------------------------------------------
  // Halt and wake-up sequencing
  // ----------------------------------------------------------------------
  wdh_pkg::wdh_wake_type cause_q;
  logic [SW-1:0] sst_cnt_q;
  logic [1:0] wake_mask_q, irq_pend;
  logic irq_wake, irq_serve, chip_rst, wait_done, extra_done;
  assign irq_pend = {irq_q[`WDH_IRQ_T1_PEND], irq_q[`WDH_IRQ_T0_PEND]};
  assign irq_wake = |(irq_pend & wake_mask_q);
  assign irq_serve = irq_q[`WDH_IRQ_GLOBAL_EN] && !i_stack_full &&
    |(irq_pend & wake_mask_q & {irq_q[`WDH_IRQ_T1_EN], irq_q[`WDH_IRQ_T0_EN]});
  assign chip_rst = ext_rst_low || (wd_ovf && (state_q != wdh_pkg::S_HALT));
  assign wait_done = (state_q == wdh_pkg::S_WAIT) && sys_en &&
    (sst_cnt_q == SW'(`WDH_SST_CYCLES - 1));
  assign extra_done = (state_q == wdh_pkg::S_EXTRA) && sys_en &&
    (sst_cnt_q == SW'(EXTRA - 1));
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= wdh_pkg::S_RUN;
      cause_q <= wdh_pkg::W_PORT;
      sst_cnt_q <= '0;
      wake_mask_q <= 2'b00;
    end
    else
    begin
      case (state_q)
        wdh_pkg::S_RUN:
        begin
          sst_cnt_q <= '0;
          if (halt_go)
          begin
            state_q <= wdh_pkg::S_HALT;
            wake_mask_q <= ~irq_pend;
          end
        end
        wdh_pkg::S_HALT:
        begin
          // A reset from the pin skips the start-up wait.
          if (ext_rst_low)
            state_q <= wdh_pkg::S_RUN;
          else if (wd_ovf || irq_wake || port_wake)
          begin
            state_q <= wdh_pkg::S_WAIT;
            if (wd_ovf)
              cause_q <= wdh_pkg::W_WARM;
            else if (irq_wake)
              cause_q <= irq_serve ? wdh_pkg::W_IRQ_SERVE : wdh_pkg::W_IRQ_NEXT;
            else
              cause_q <= wdh_pkg::W_PORT;
          end
        end
        wdh_pkg::S_WAIT:
        begin
          if (ext_rst_low)
            state_q <= wdh_pkg::S_RUN;
          else if (wait_done)
          begin
            sst_cnt_q <= '0;
            state_q <= (cause_q == wdh_pkg::W_IRQ_SERVE) ? wdh_pkg::S_EXTRA : wdh_pkg::S_RUN;
          end
          else if (sys_en)
            sst_cnt_q <= sst_cnt_q + SW'(1);
        end
        wdh_pkg::S_EXTRA:
        begin
          if (ext_rst_low || extra_done)
            state_q <= wdh_pkg::S_RUN;
          else if (sys_en)
            sst_cnt_q <= sst_cnt_q + SW'(1);
        end
        default:
          state_q <= wdh_pkg::S_RUN;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_halt <= 1'b0;
      o_chip_rst <= 1'b0;
      o_warm_rst <= 1'b0;
      o_resume_next <= 1'b0;
      o_irq_service <= 1'b0;
    end
    else
    begin
      o_halt <= (state_q == wdh_pkg::S_RUN) ? halt_go :
        ((state_q == wdh_pkg::S_HALT) && !ext_rst_low && !wd_ovf && !irq_wake && !port_wake);
      o_chip_rst <= chip_rst;
      o_warm_rst <= wait_done && !ext_rst_low && (cause_q == wdh_pkg::W_WARM);
      o_resume_next <= wait_done && !ext_rst_low &&
        ((cause_q == wdh_pkg::W_PORT) || (cause_q == wdh_pkg::W_IRQ_NEXT));
      o_irq_service <= extra_done && !ext_rst_low;
    end
  end
  // ----------------------------------------------------------------------
  // Flags and registers
  // ----------------------------------------------------------------------
  logic to_q, pdf_q, wr_en, rd_phase;
  logic hit_stat, hit_irq, hit_ps;
  logic [7:0] rdata;
  assign hit_stat = (i_paddr[11:2] == `WDH_IDX_STATUS) && (i_paddr[1:0] == 2'b00);
  assign hit_irq = (i_paddr[11:2] == `WDH_IDX_IRQ_CTRL) && (i_paddr[1:0] == 2'b00);
  assign hit_ps = (i_paddr[11:2] == `WDH_IDX_WD_PRESCALE) && (i_paddr[1:0] == 2'b00);
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign rd_phase = i_psel && i_penable && !o_pready;
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end
    else
    begin
      // Sleep flag: halt wins over a same-cycle clear; expired flag: a same-cycle clear masks the overflow.
      if (wd_ovf)
        to_q <= 1'b1;
      else if (wd_sw_clear || halt_go)
        to_q <= 1'b0;
      if (halt_go)
        pdf_q <= 1'b1;
      else if (wd_sw_clear)
        pdf_q <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ps_q <= `WDH_PS_RESET;
    else if (chip_rst)
      ps_q <= `WDH_PS_RESET;
    else if (WD_ENABLE && wr_en && hit_ps)
      ps_q <= i_pwdata[7:0];
  end
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= `WDH_IRQ_RESET;
    else if (chip_rst)
      irq_q <= `WDH_IRQ_RESET;
    else
    begin
      if (wr_en && hit_irq)
        irq_q <= i_pwdata[7:0] & `WDH_IRQ_RW_MASK;
      if (i_timer0_irq_set)
        irq_q[`WDH_IRQ_T0_PEND] <= 1'b1;
      if (i_timer1_irq_set)
        irq_q[`WDH_IRQ_T1_PEND] <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // APB slave with one wait state
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata = 8'h00;
    if (hit_stat)
    begin
      rdata[`WDH_STAT_TO] = to_q;
      rdata[`WDH_STAT_PDF] = pdf_q;
    end
    else if (hit_irq)
      rdata = irq_q & `WDH_IRQ_RW_MASK;
    else if (hit_ps)
      rdata = ps_q;
  end
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= rd_phase;
      if (rd_phase)
      begin
        o_prdata <= {24'h00_0000, rdata};
        o_pslverr <= !(hit_stat || hit_irq || hit_ps);
      end
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);
  property p_sys_div;
    sys_en |=> !sys_en;
  endproperty
  a_sys_div: assert property (p_sys_div) else $error("System enable not halved.");
  property p_clkout;
    RC_MODE && sys_en && instr_cnt_q[0] |=> (o_clock_pin_out != $past(o_clock_pin_out));
  endproperty
  a_clkout: assert property (p_clkout) else $error("Clock pin did not toggle.");
  property p_wd_off;
    !WD_ENABLE |-> (wd_cnt_q == '0) && !wd_ovf;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("Disabled watchdog counted.");
  property p_restart;
    wd_ovf |=> (wd_cnt_q == '0) && !wd_ovf;
  endproperty
  a_restart: assert property (p_restart) else $error("Counter kept value after overflow.");
  property p_run_ovf;
    wd_ovf && (state_q == wdh_pkg::S_RUN) |=> o_chip_rst && to_q;
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("Overflow did not reset chip.");
  property p_clear;
    wd_clear |=> (wd_cnt_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("Clear left count.");
  property p_halt_flags;
    halt_go |=> pdf_q && !to_q && o_halt;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("Halt flags wrong.");
  property p_pdf_clr;
    wd_sw_clear && !halt_go |=> !pdf_q;
  endproperty
  a_pdf_clr: assert property (p_pdf_clr) else $error("Sleep flag not cleared.");
  property p_halt_osc;
    (state_q == wdh_pkg::S_HALT) |-> !sys_en;
  endproperty
  a_halt_osc: assert property (p_halt_osc) else $error("Oscillator ran in halt.");
  property p_sst;
    o_resume_next || o_warm_rst |-> $past(sst_cnt_q) == SW'(`WDH_SST_CYCLES - 1);
  endproperty
  a_sst: assert property (p_sst) else $error("Wake wait length wrong.");
  property p_old_pend;
    halt_go && irq_pend[1] |=> !wake_mask_q[1];
  endproperty
  a_old_pend: assert property (p_old_pend) else $error("Old request can wake.");
  c_port_wake: cover property (o_resume_next && (cause_q == wdh_pkg::W_PORT));
  c_warm: cover property (o_warm_rst);
  c_service: cover property (o_irq_service);
  c_run_rst: cover property (wd_ovf && state_q == wdh_pkg::S_RUN);
endmodule : wdh_watchdog_halt
`default_nettype wire

/* File: wdh_watchdog_halt_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdh_map.svh"
module wdh_watchdog_halt_tb;
  localparam logic [11:0] A_ST = {`WDH_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_IRQ = {`WDH_IDX_IRQ_CTRL, 2'b00};
  localparam logic [11:0] A_PS = {`WDH_IDX_WD_PRESCALE, 2'b00};
  localparam logic [11:0] A_BAD = 12'h040;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_rst_n = 1'b1;
  logic wd_osc = 1'b0;
  logic halt_exec = 1'b0;
  logic clr_s = 1'b0;
  logic stack_full = 1'b0;
  logic t0_set = 1'b0;
  logic t1_set = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] port_a = 8'hff;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, sys_clk_en, clk_out, halt, chip_rst, warm_rst, resume_next, irq_service;
  logic [31:0] prdata, rd;
  logic err;
  int bad_count = 0;
  int compares = 0;
  int chip_cnt = 0;
  wdh_watchdog_halt dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_external_rst_n(ext_rst_n),
    .i_wd_osc(wd_osc), .i_port_a(port_a), .i_halt_exec(halt_exec), .i_wd_clear_single(clr_s),
    .i_wd_clear_first(1'b0), .i_wd_clear_second(1'b0), .i_stack_full(stack_full),
    .i_timer0_irq_set(t0_set), .i_timer1_irq_set(t1_set), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_sys_clk_en(sys_clk_en),
    .o_clock_pin_out(clk_out), .o_halt(halt), .o_chip_rst(chip_rst), .o_warm_rst(warm_rst),
    .o_resume_next(resume_next), .o_irq_service(irq_service));
  // ----------------------------------------------------------------------
  // Clocks and monitors.
  // ----------------------------------------------------------------------
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  // The watchdog oscillator runs free at one tick per 12 reference clocks.
  // A base time-out longer than the wake wait keeps a second overflow out of it.
  initial
  begin
    forever
    begin
      repeat (6) @(posedge ref_clk);
      wd_osc <= ~wd_osc;
    end
  end
  always @(posedge ref_clk)
  begin
    if (chip_rst === 1'b1)
      chip_cnt <= chip_cnt + 1;
  end
  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic close_out;
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int n, input int lo, input int hi, input string what);
    compares++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("ERROR %0t %s took %0d cycles", $time, what, n);
    end
  endtask : chk_rng
  // Flop outputs read just after a rising edge still show what that edge sampled.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1, "apb timeout");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdchk
  task automatic pulse(input int which);
    @(posedge ref_clk);
    case (which)
      0: halt_exec <= 1'b1;
      1: clr_s <= 1'b1;
      2: t0_set <= 1'b1;
      default: t1_set <= 1'b1;
    endcase
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    clr_s <= 1'b0;
    t0_set <= 1'b0;
    t1_set <= 1'b0;
  endtask : pulse
  task automatic wait_for(input int which, input int lim, output int n);
    logic s;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      case (which)
        0: s = chip_rst;
        1: s = warm_rst;
        2: s = resume_next;
        3: s = irq_service;
        default: s = ~halt;
      endcase
    end while (s !== 1'b1 && n < lim);
    if (n >= lim)
      chk(32'h0, 32'h1, "wait timeout");
  endtask : wait_for
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rdchk(A_ST, 32'h00, "status reset");
    rdchk(A_IRQ, 32'h00, "irq reset");
    rdchk(A_PS, 32'h07, "prescale reset");
    wr(A_IRQ, 32'hff);
    rdchk(A_IRQ, 32'h6d, "irq unused bits");
    wr(A_PS, 32'hf9);
    rdchk(A_PS, 32'hf9, "prescale flag bits");
    wr(A_ST, 32'hff);
    rdchk(A_ST, 32'h00, "status flags not writable");
    apb(1'b0, A_BAD, 32'h0);
    chk(err, 1'b1, "unmapped read");
    wr(A_IRQ, 32'h00);
    wr(A_PS, 32'h01);
  endtask : t_regs
  task automatic t_clocks;
    int a, b;
    logic prev;
    a = 0;
    b = 0;
    prev = clk_out;
    repeat (64)
    begin
      @(negedge ref_clk);
      if (sys_clk_en === 1'b1)
        a++;
      if (clk_out === 1'b1 && prev !== 1'b1)
        b++;
      prev = clk_out;
    end
    chk(a, 32, "system clock rate");
    chk(b, 8, "clock pin rate");
  endtask : t_clocks
  task automatic t_clear_overflow;
    int c0, n;
    wr(A_PS, 32'h00);
    pulse(1);
    c0 = chip_cnt;
    repeat (4)
    begin
      repeat (1500) @(posedge ref_clk);
      pulse(1);
    end
    chk(chip_cnt - c0, 0, "clears hold off overflow");
    wait_for(0, 3300, n);
    chk_rng(n, 3050, 3090, "overflow period");
    rdchk(A_ST, 32'h20, "expired flag");
  endtask : t_clear_overflow
  task automatic t_halt_port;
    int n;
    wr(A_PS, 32'h01);
    wr(A_IRQ, 32'h05);
    pulse(1);
    pulse(0);
    @(negedge ref_clk);
    chk(halt, 1'b1, "halt pin");
    rdchk(A_ST, 32'h10, "halt flags");
    @(posedge ref_clk);
    port_a <= 8'hfe;
    wait_for(4, 20, n);
    wait_for(2, 2100, n);
    chk_rng(n, 2040, 2056, "port wake wait");
    rdchk(A_IRQ, 32'h05, "state kept over halt");
    @(posedge ref_clk);
    port_a <= 8'hff;
    pulse(1);
    rdchk(A_ST, 32'h00, "clear drops sleep flag");
  endtask : t_halt_port
  task automatic t_halt_wd;
    int n, c0;
    wr(A_PS, 32'h00);
    c0 = chip_cnt;
    pulse(0);
    wait_for(1, 5400, n);
    chk_rng(n, 5090, 5150, "overflow wake wait");
    chk(chip_cnt - c0, 0, "no chip reset in halt");
    rdchk(A_ST, 32'h30, "warm reset flags");
    rdchk(A_PS, 32'h00, "prescale kept");
    wr(A_PS, 32'h01);
    pulse(1);
  endtask : t_halt_wd
  task automatic t_irq;
    int n;
    wr(A_IRQ, 32'h0d);
    pulse(3);
    rdchk(A_IRQ, 32'h4d, "timer1 pending");
    pulse(0);
    repeat (100) @(negedge ref_clk);
    chk(halt, 1'b1, "stale pending no wake");
    pulse(2);
    wait_for(4, 20, n);
    wait_for(3, 2200, n);
    chk_rng(n, 2048, 2064, "service wait");
    wr(A_IRQ, 32'h05);
    @(posedge ref_clk);
    stack_full <= 1'b1;
    pulse(1);
    pulse(0);
    pulse(2);
    wait_for(4, 20, n);
    wait_for(2, 2200, n);
    chk_rng(n, 2040, 2056, "stack full resumes next");
    @(posedge ref_clk);
    stack_full <= 1'b0;
  endtask : t_irq
  // Reset pin in halt: no start-up wait, registers back to reset, flags untouched.
  task automatic t_ext;
    int c0;
    wr(A_IRQ, 32'h05);
    wr(A_PS, 32'h3a);
    pulse(0);
    c0 = chip_cnt;
    @(posedge ref_clk);
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(halt, 1'b0, "reset pin leaves halt");
    chk(chip_cnt > c0, 1'b1, "reset pin chip reset");
    rdchk(A_IRQ, 32'h00, "irq cleared by pin");
    rdchk(A_PS, 32'h07, "prescale cleared by pin");
    rdchk(A_ST, 32'h10, "flags after pin wake");
  endtask : t_ext
  // ----------------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_clocks();
    t_clear_overflow();
    t_halt_port();
    t_halt_wd();
    t_irq();
    t_ext();
    close_out();
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
endmodule : wdh_watchdog_halt_tb
`default_nettype wire
